// file: pkg/sbt_pkg.sv
// Purpose: Shared constants and types for the SRAM boundary-scan TAP.
// Assumes: One 100 MHz pclk domain; TCK, TMS and TDI arrive as async pins.
// Notes:   Register offsets are byte addresses on a 32-bit APB slave.
package sbt_pkg;
   // ----------------------------------------------------------------
   // Scan register geometry
   // ----------------------------------------------------------------
   localparam int SBT_IR_W = 3;
   localparam int SBT_BSR_W = 109;
   localparam int SBT_ID_W = 32;
   localparam int SBT_OE_CELL = 108;

   // ----------------------------------------------------------------
   // Instruction codes and capture patterns
   // ----------------------------------------------------------------
   localparam logic [2:0] SBT_INS_EXTEST = 3'h0;
   localparam logic [2:0] SBT_INS_IDENT_SELECT = 3'h1;
   localparam logic [2:0] SBT_INS_SAMPLE_Z = 3'h2;
   localparam logic [2:0] SBT_INS_SAMPLE = 3'h4;
   localparam logic [2:0] SBT_INS_BYPASS = 3'h7;
   localparam logic [2:0] SBT_IR_CAPTURE = 3'h1;
   localparam logic [2:0] SBT_IR_RESET = SBT_INS_IDENT_SELECT;
   localparam logic SBT_BYP_CAPTURE = 1'h0;
   localparam logic SBT_OE_RESET = 1'h0;
   localparam logic SBT_ID_PRESENT = 1'h1;

   // ----------------------------------------------------------------
   // APB register map
   // ----------------------------------------------------------------
   localparam int SBT_APB_AW = 12;
   localparam logic [11:0] SBT_ADDR_CTRL = 12'h000;
   localparam logic [11:0] SBT_ADDR_STAT = 12'h004;
   localparam logic [11:0] SBT_ADDR_IDV = 12'h008;
   localparam int SBT_CTRL_HOLD_BIT = 0;
   localparam logic SBT_CTRL_HOLD_RESET = 1'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_TLR, S_RTI, S_SELDR, S_CAPDR, S_SHDR, S_EX1DR, S_PAUDR, S_EX2DR,
      S_UPDR, S_SELIR, S_CAPIR, S_SHIR, S_EX1IR, S_PAUIR, S_EX2IR, S_UPIR
   } sbt_tap_state_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } sbt_jtag_t;
endpackage

// file: verilog/sbt_sync.sv
// Purpose: Two-stage synchroniser for a bundle of async levels.
// Assumes: Each bit is an independent level; no bus coherency is implied.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
module sbt_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// file: verilog/sbt_tap.sv
// Purpose: Boundary-scan TAP for a synchronous SRAM, with APB status.
// Assumes: TCK is far slower than pclk and is sampled, not used as a clock.
// Notes:   TDO and all pin controls are registered on pclk.
// Contract
// - Three-bit instruction register shifted TDI to TDO
// - Identification-select loaded at reset and TLR
// - Capture-IR loads 01 into low bits
// - Bypass bit captures zero
// - Bypass routes TDI to TDO in Shift-DR
// - Boundary register captures pins, shifts in Shift-DR
// - Cell per bump, TDI at MSB, LSB to TDO
// - Identification value captured in Capture-DR
// - Identification value shifted out in Shift-DR
// - New instruction applied only at Update-IR
// - Sample-Z selects boundary register, read bus off
// - Sample snapshots pins, core runs undisturbed
// - Update latches preload shifted pattern
// - Preload shifts in while sample shifts out
// - Extest drives latches onto pins, boundary selected
// - Cell 108 latch gates read bus under extest
// - Enable latch cleared at reset and TLR
// - Sample TMS/TDI rising, TDO changes falling
// - Five TMS-high edges reach reset state
// - Decode 000,001,010,100,111; others reserved
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module sbt_tap import sbt_pkg::*; #(
   parameter logic [2:0] ID_REV = 3'h0,        // Arbitrary value
   parameter logic [16:0] ID_PART = 17'h00a5c, // Arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h2b3   // Arbitrary value
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [SBT_APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   input wire logic [SBT_BSR_W-1:0] pins_in,
   input wire logic core_rd_oe,
   output logic [SBT_BSR_W-1:0] bsr_latch_q,
   output logic extest_q,
   output logic rd_oe_q
);
   // ----------------------------------------------------------------
   // Pin synchronisation and TCK edge detection
   // ----------------------------------------------------------------
   sbt_jtag_t jt_raw;
   sbt_jtag_t jt_s;
   logic [SBT_BSR_W-1:0] pins_s;
   logic tck_prev_q, tck_prev_d;
   logic rise, fall;

   assign jt_raw = '{tck: tck, tms: tms, tdi: tdi};

   sbt_sync #(.W($bits(sbt_jtag_t))) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(jt_raw),
      .q(jt_s)
   );

   // Pins move with the SRAM clock; a capture may still catch a bit in flight
   sbt_sync #(.W(SBT_BSR_W)) u_pin_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(pins_in),
      .q(pins_s)
   );

   // TMS and TDI go through the same two stages as TCK, so they stay
   // aligned with the detected edge
   assign rise = jt_s.tck & ~tck_prev_q;
   assign fall = ~jt_s.tck & tck_prev_q;

   // ----------------------------------------------------------------
   // TAP state transition
   // ----------------------------------------------------------------
   function automatic sbt_tap_state_t tap_next(input sbt_tap_state_t s, input logic m);
      sbt_tap_state_t n;
      n = s;
      case (s)
         S_TLR: n = m ? S_TLR : S_RTI;
         S_RTI: n = m ? S_SELDR : S_RTI;
         S_SELDR: n = m ? S_SELIR : S_CAPDR;
         S_CAPDR: n = m ? S_EX1DR : S_SHDR;
         S_SHDR: n = m ? S_EX1DR : S_SHDR;
         S_EX1DR: n = m ? S_UPDR : S_PAUDR;
         S_PAUDR: n = m ? S_EX2DR : S_PAUDR;
         S_EX2DR: n = m ? S_UPDR : S_SHDR;
         S_UPDR: n = m ? S_SELDR : S_RTI;
         S_SELIR: n = m ? S_TLR : S_CAPIR;
         S_CAPIR: n = m ? S_EX1IR : S_SHIR;
         S_SHIR: n = m ? S_EX1IR : S_SHIR;
         S_EX1IR: n = m ? S_UPIR : S_PAUIR;
         S_PAUIR: n = m ? S_EX2IR : S_PAUIR;
         S_EX2IR: n = m ? S_UPIR : S_SHIR;
         S_UPIR: n = m ? S_SELDR : S_RTI;
         default: n = S_TLR;
      endcase
      return n;
   endfunction

   // ----------------------------------------------------------------
   // TAP datapath state
   // ----------------------------------------------------------------
   sbt_tap_state_t st_q, st_d;
   logic [SBT_IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
   logic byp_q, byp_d;
   logic [SBT_ID_W-1:0] id_q, id_d;
   logic [SBT_BSR_W-1:0] bsr_q, bsr_d, upd_d;
   logic tdo_d, tdo_oe_d, extest_d, rd_oe_d;
   logic sel_bsr, sel_id, dr_lsb, boundary_upd, hold_q;
   logic [SBT_ID_W-1:0] id_value;

   assign id_value = {ID_REV, ID_PART, ID_MAKER, SBT_ID_PRESENT};

   // Reserved codes fall through to the bypass path, a safe one-bit chain
   assign sel_bsr = (ir_q == SBT_INS_EXTEST) || (ir_q == SBT_INS_SAMPLE)
                    || (ir_q == SBT_INS_SAMPLE_Z);
   assign sel_id = (ir_q == SBT_INS_IDENT_SELECT);
   assign boundary_upd = (ir_q == SBT_INS_EXTEST) || (ir_q == SBT_INS_SAMPLE);
   assign dr_lsb = sel_bsr ? bsr_q[0] : (sel_id ? id_q[0] : byp_q);

   always_comb begin
      st_d = st_q;
      ir_sh_d = ir_sh_q;
      ir_d = ir_q;
      byp_d = byp_q;
      id_d = id_q;
      bsr_d = bsr_q;
      upd_d = bsr_latch_q;
      tdo_d = tdo;
      tdo_oe_d = tdo_oe;
      tck_prev_d = jt_s.tck;
      if (hold_q) begin
         // Software hold parks the TAP as if TMS were stuck high
         st_d = S_TLR;
         ir_d = SBT_IR_RESET;
         upd_d[SBT_OE_CELL] = SBT_OE_RESET;
         tdo_oe_d = 1'b0;
      end else if (rise) begin
         st_d = tap_next(st_q, jt_s.tms);
         case (st_q)
            S_TLR: begin
               ir_d = SBT_IR_RESET;
               upd_d[SBT_OE_CELL] = SBT_OE_RESET;
            end
            S_CAPIR: ir_sh_d = SBT_IR_CAPTURE;
            S_SHIR: ir_sh_d = {jt_s.tdi, ir_sh_q[SBT_IR_W-1:1]};
            S_UPIR: ir_d = ir_sh_q;
            S_CAPDR: begin
               if (sel_bsr) begin
                  // Only a snapshot; the core keeps running
                  bsr_d = pins_s;
               end else if (sel_id) begin
                  id_d = id_value;
               end else begin
                  byp_d = SBT_BYP_CAPTURE;
               end
            end
            S_SHDR: begin
               if (sel_bsr) begin
                  // New preload enters at the MSB as samples leave
                  bsr_d = {jt_s.tdi, bsr_q[SBT_BSR_W-1:1]};
               end else if (sel_id) begin
                  id_d = {jt_s.tdi, id_q[SBT_ID_W-1:1]};
               end else begin
                  byp_d = jt_s.tdi;
               end
            end
            S_UPDR: begin
               if (boundary_upd) begin
                  upd_d = bsr_q;
               end
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         // TDO only moves here, half a TCK period after the shift
         tdo_oe_d = (st_q == S_SHIR) || (st_q == S_SHDR);
         tdo_d = (st_q == S_SHIR) ? ir_sh_q[0] : dr_lsb;
      end
      extest_d = (ir_q == SBT_INS_EXTEST);
      if (ir_q == SBT_INS_SAMPLE_Z) begin
         rd_oe_d = 1'b0;
      end else if (ir_q == SBT_INS_EXTEST) begin
         rd_oe_d = bsr_latch_q[SBT_OE_CELL];
      end else begin
         rd_oe_d = core_rd_oe;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= S_TLR;
         ir_sh_q <= SBT_IR_CAPTURE;
         ir_q <= SBT_IR_RESET;
         byp_q <= SBT_BYP_CAPTURE;
         id_q <= '0;
         bsr_q <= '0;
         bsr_latch_q <= '0;
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
         tck_prev_q <= 1'b0;
         extest_q <= 1'b0;
         rd_oe_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ir_sh_q <= ir_sh_d;
         ir_q <= ir_d;
         byp_q <= byp_d;
         id_q <= id_d;
         bsr_q <= bsr_d;
         bsr_latch_q <= upd_d;
         tdo <= tdo_d;
         tdo_oe <= tdo_oe_d;
         tck_prev_q <= tck_prev_d;
         extest_q <= extest_d;
         rd_oe_q <= rd_oe_d;
      end
   end

   // ----------------------------------------------------------------
   // APB slave: one wait state, reads registered
   // ----------------------------------------------------------------
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d, hold_d;
   logic [31:0] stat_word;

   assign stat_word = {23'h000000, tdo_oe, rd_oe_q, ir_q, st_q};

   always_comb begin
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = prdata;
      hold_d = hold_q;
      if (psel && penable && !pready) begin
         // Answer prepared in the first access cycle, shown in the next
         pready_d = 1'b1;
         prdata_d = 32'h00000000;
         if (paddr == SBT_ADDR_CTRL) begin
            prdata_d[SBT_CTRL_HOLD_BIT] = hold_q;
         end else if (paddr == SBT_ADDR_STAT) begin
            prdata_d = stat_word;
            pslverr_d = pwrite;
         end else if (paddr == SBT_ADDR_IDV) begin
            prdata_d = id_value;
            pslverr_d = pwrite;
         end else begin
            pslverr_d = 1'b1;
         end
      end
      // Writes commit only on the edge that completes the access
      if (psel && penable && pready && pwrite && paddr == SBT_ADDR_CTRL) begin
         hold_d = pwdata[SBT_CTRL_HOLD_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         hold_q <= SBT_CTRL_HOLD_RESET;
      end else begin
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         hold_q <= hold_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [2:0] tms_run_q;
   logic oe_cell;

   assign oe_cell = bsr_latch_q[SBT_OE_CELL];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tms_run_q <= 3'h0;
      end else if (rise) begin
         tms_run_q <= !jt_s.tms ? 3'h0 : (tms_run_q == 3'h5 ? 3'h5 : tms_run_q + 3'h1);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ir_reset;
      rise && !hold_q && st_q == S_TLR |=> ir_q == SBT_INS_IDENT_SELECT;
   endproperty
   a_ir_reset: assert property (p_ir_reset) else $error("IR not reset in TLR");

   property p_ir_capture;
      rise && !hold_q && st_q == S_CAPIR |=> ir_sh_q[1:0] == 2'b01;
   endproperty
   a_ir_capture: assert property (p_ir_capture) else $error("Capture-IR pattern wrong");

   property p_ir_update;
      $changed(ir_q) |-> $past(hold_q) || ($past(rise)
         && ($past(st_q) == S_UPIR || $past(st_q) == S_TLR));
   endproperty
   a_ir_update: assert property (p_ir_update) else $error("IR changed outside update");

   property p_byp_capture;
      rise && !hold_q && st_q == S_CAPDR && ir_q == SBT_INS_BYPASS |=> !byp_q;
   endproperty
   a_byp_capture: assert property (p_byp_capture) else $error("Bypass capture not zero");

   property p_id_capture;
      rise && !hold_q && st_q == S_CAPDR && sel_id |=> id_q == id_value;
   endproperty
   a_id_capture: assert property (p_id_capture) else $error("ID value not captured");

   property p_tdo_fall;
      $changed(tdo) |-> $past(fall);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("TDO moved off a falling edge");

   property p_bypass_out;
      fall && !hold_q && st_q == S_SHDR && ir_q == SBT_INS_BYPASS
         |=> tdo == $past(byp_q) && tdo_oe;
   endproperty
   a_bypass_out: assert property (p_bypass_out) else $error("Bypass bit not on TDO");

   property p_five_tms;
      tms_run_q == 3'h5 |-> st_q == S_TLR;
   endproperty
   a_five_tms: assert property (p_five_tms) else $error("Five TMS highs missed reset");

   property p_sample_z;
      ir_q == SBT_INS_SAMPLE_Z ##1 ir_q == SBT_INS_SAMPLE_Z |-> !rd_oe_q;
   endproperty
   a_sample_z: assert property (p_sample_z) else $error("Read bus on under sample-z");

   property p_extest_oe;
      ir_q == SBT_INS_EXTEST |=> rd_oe_q == $past(oe_cell) && extest_q;
   endproperty
   a_extest_oe: assert property (p_extest_oe) else $error("Enable cell not obeyed");

   property p_oe_reset;
      rise && !hold_q && st_q == S_TLR |=> !oe_cell;
   endproperty
   a_oe_reset: assert property (p_oe_reset) else $error("Enable latch not cleared");
endmodule

// file: dv/sbt_host.sv
// Purpose: Board-level scan controller model that drives the TAP pins.
// Assumes: Its tasks are entered at a pclk rising edge while tck is low.
// Notes:   TCK runs only inside frames (80 ns period) and rests low between them.
`timescale 1ns/10ps
module sbt_host import sbt_pkg::*; (
   input wire logic pclk,
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   // ----------------------------------------------------------------
   // Pin cycling
   // ----------------------------------------------------------------
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // TDO is read late in the high phase, long after the previous fall settled
   task automatic bit_io(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge pclk);
      tck <= 1'b1;
      repeat (4) @(posedge pclk);
      o = tdo;
      tck <= 1'b0;
   endtask

   // Between frames the pins fall back to their pulled-up level
   task automatic idle();
      tdi <= 1'b1;
      tms <= 1'b1;
      repeat (8) @(posedge pclk);
   endtask

   task automatic walk(input logic [7:0] m, input int n);
      logic o;
      for (int i = 0; i < n; i++) begin
         bit_io(m[i], 1'b1, o);
      end
   endtask

   task automatic tap_reset();
      walk(8'h1f, 5);
      idle();
   endtask

   // ----------------------------------------------------------------
   // Scans
   // ----------------------------------------------------------------
   // Only the five decoded codes are ever issued
   task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
      logic o;
      walk(8'h06, 5);
      for (int i = 0; i < SBT_IR_W; i++) begin
         bit_io(i == SBT_IR_W - 1, code[i], o);
         cap[i] = o;
      end
      walk(8'h01, 2);
      idle();
   endtask

   task automatic scan_dr(input int n, input logic [SBT_BSR_W-1:0] din,
                          output logic [SBT_BSR_W-1:0] dout);
      logic o;
      dout = '0;
      walk(8'h02, 4);
      for (int i = 0; i < n; i++) begin
         bit_io(i == n - 1, din[i], o);
         dout[i] = o;
      end
      walk(8'h01, 2);
      idle();
   endtask
endmodule

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the SRAM boundary-scan TAP.
// Assumes: Scan traffic comes from the controller model; APB from local tasks.
// Notes:   Expected values come from the scan rules and bench constants.
`timescale 1ns/10ps
module tb_top import sbt_pkg::*; ;
   typedef logic [SBT_BSR_W-1:0] sbt_vec_t;
   localparam logic [2:0] IDR = 3'h5; // Arbitrary value
   localparam logic [16:0] IDP = 17'h0c3a1; // Arbitrary value
   localparam logic [10:0] IDM = 11'h1e7; // Arbitrary value
   localparam logic [31:0] ID_EXP = {IDR, IDP, IDM, 1'b1};
   localparam sbt_vec_t PAT_A = {1'b1, {27{4'h9}}};
   localparam sbt_vec_t PRE_A = {1'b1, {27{4'h3}}};
   localparam sbt_vec_t PRE_B = {1'b0, {27{4'hc}}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic tck, tms, tdi, tdo, tdo_oe, core_rd_oe, extest_q, rd_oe_q;
   logic tdo_line;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   sbt_vec_t pins_in, bsr_latch_q;
   int failures = 0;
   int n_checks = 0;

   sbt_tap #(.ID_REV(IDR), .ID_PART(IDP), .ID_MAKER(IDM)) u_sbt_tap (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .pins_in(pins_in), .core_rd_oe(core_rd_oe),
      .bsr_latch_q(bsr_latch_q), .extest_q(extest_q), .rd_oe_q(rd_oe_q)
   );
   // TDO has no pull; a released pin reads inverted, so a late enable shows up
   assign tdo_line = tdo_oe ? tdo : ~tdo;
   sbt_host u_sbt_host (.pclk(pclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic test_done();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input sbt_vec_t got, input sbt_vec_t exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         failures++;
         $display("Error %0t: APB access timed out", $time);
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] d;
      logic e;
      apb(1'b0, SBT_ADDR_STAT, 32'h0, d, e);
      chk(sbt_vec_t'(d[8:0]), sbt_vec_t'(9'h090), "reset state");
      chk(bsr_latch_q, '0, "reset latch");
      apb(1'b0, SBT_ADDR_IDV, 32'h0, d, e);
      chk(sbt_vec_t'(d), sbt_vec_t'(ID_EXP), "id value");
      apb(1'b0, 12'h00c, 32'h0, d, e);
      chk(sbt_vec_t'({e, d}), sbt_vec_t'(33'h100000000), "unmapped");
      apb(1'b1, SBT_ADDR_STAT, 32'hffffffff, d, e);
      chk(sbt_vec_t'(e), sbt_vec_t'(1'b1), "ro write");
      apb(1'b1, SBT_ADDR_CTRL, 32'h1, d, e);
      apb(1'b0, SBT_ADDR_CTRL, 32'h0, d, e);
      chk(sbt_vec_t'(d), sbt_vec_t'(32'h1), "ctrl");
      apb(1'b1, SBT_ADDR_CTRL, 32'h0, d, e);
   endtask

   task automatic t_ident();
      sbt_vec_t o;
      u_sbt_host.scan_dr(SBT_ID_W, '0, o);
      chk(o, sbt_vec_t'(ID_EXP), "id shift");
   endtask

   task automatic t_bypass();
      logic [2:0] c;
      logic [31:0] d;
      logic e;
      sbt_vec_t o;
      u_sbt_host.load_ir(SBT_INS_BYPASS, c);
      chk(sbt_vec_t'(c), sbt_vec_t'(3'h1), "ir capture");
      apb(1'b0, SBT_ADDR_STAT, 32'h0, d, e);
      chk(sbt_vec_t'(d[6:4]), sbt_vec_t'(3'h7), "ir applied");
      u_sbt_host.scan_dr(8, sbt_vec_t'(8'hb6), o);
      chk(o, sbt_vec_t'(8'h6c), "bypass");
   endtask

   task automatic t_sample();
      logic [2:0] c;
      sbt_vec_t o;
      pins_in <= PAT_A;
      core_rd_oe <= 1'b1;
      u_sbt_host.load_ir(SBT_INS_SAMPLE, c);
      u_sbt_host.scan_dr(SBT_BSR_W, PRE_A, o);
      chk(o, PAT_A, "sample out");
      chk(bsr_latch_q, PRE_A, "preload");
      chk(sbt_vec_t'({extest_q, rd_oe_q}), sbt_vec_t'(2'h1), "sample oe");
   endtask

   task automatic t_extest();
      logic [2:0] c;
      sbt_vec_t o;
      pins_in <= ~PAT_A;
      u_sbt_host.load_ir(SBT_INS_EXTEST, c);
      chk(sbt_vec_t'({extest_q, rd_oe_q}), sbt_vec_t'(2'h3), "extest on");
      chk(bsr_latch_q, PRE_A, "extest drive");
      u_sbt_host.scan_dr(SBT_BSR_W, PRE_B, o);
      chk(o, ~PAT_A, "extest out");
      chk(sbt_vec_t'({extest_q, rd_oe_q}), sbt_vec_t'(2'h2), "extest hiz");
      chk(bsr_latch_q, PRE_B, "extest latch");
   endtask

   task automatic t_samplez();
      logic [2:0] c;
      sbt_vec_t o;
      core_rd_oe <= 1'b1;
      u_sbt_host.load_ir(SBT_INS_SAMPLE_Z, c);
      chk(sbt_vec_t'(rd_oe_q), '0, "hiz");
      u_sbt_host.scan_dr(SBT_BSR_W, PRE_A, o);
      chk(o, ~PAT_A, "hiz path");
      chk(sbt_vec_t'(rd_oe_q), '0, "hiz hold");
      u_sbt_host.load_ir(SBT_INS_BYPASS, c);
      chk(sbt_vec_t'(rd_oe_q), sbt_vec_t'(1'b1), "hiz end");
   endtask

   task automatic t_tlr();
      logic [2:0] c;
      logic [31:0] d;
      logic e;
      sbt_vec_t o;
      u_sbt_host.load_ir(SBT_INS_SAMPLE, c);
      u_sbt_host.scan_dr(SBT_BSR_W, PRE_A, o);
      chk(sbt_vec_t'(bsr_latch_q[SBT_OE_CELL]), sbt_vec_t'(1'b1), "oe set");
      u_sbt_host.tap_reset();
      chk(sbt_vec_t'(bsr_latch_q[SBT_OE_CELL]), '0, "oe clear");
      apb(1'b0, SBT_ADDR_STAT, 32'h0, d, e);
      chk(sbt_vec_t'(d[6:0]), sbt_vec_t'(7'h10), "tap reset");
      u_sbt_host.load_ir(SBT_INS_SAMPLE_Z, c);
      apb(1'b1, SBT_ADDR_CTRL, 32'h1, d, e);
      apb(1'b0, SBT_ADDR_STAT, 32'h0, d, e);
      chk(sbt_vec_t'(d[7:0]), sbt_vec_t'(8'h90), "hold park");
      apb(1'b1, SBT_ADDR_CTRL, 32'h0, d, e);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pins_in = '0;
      core_rd_oe = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_ident();
      t_bypass();
      t_sample();
      t_extest();
      t_samplez();
      t_tlr();
      test_done();
   end

   // The whole run needs well under 100 us of scan traffic
   initial begin
      #500us;
      failures++;
      $display("Error %0t: watchdog expired", $time);
      test_done();
   end
endmodule
